// ### shared/excitation_bias_pkg.sv
package excitation_bias_pkg;

    // Register offsets as byte addresses (every printed offset is a multiple of four, the index times four).
    localparam logic [7:0] MAG_INDEX = 8'h06;
    localparam logic [7:0] ROUTE_INDEX = 8'h07;
    localparam logic [7:0] BIAS_INDEX = 8'h08;
    localparam logic [11:0] MAG_ADDR = 12'h018;
    localparam logic [11:0] ROUTE_ADDR = 12'h01C;
    localparam logic [11:0] BIAS_ADDR = 12'h020;

    // Reset values.
    localparam logic [7:0] MAG_RESET = 8'h00;
    localparam logic [7:0] ROUTE_RESET = 8'hFF;
    localparam logic [7:0] BIAS_RESET = 8'h00;

    // Field positions and masks.
    localparam int RAIL_BIT = 7;
    localparam int SWITCH_BIT = 6;
    localparam logic [7:0] MAG_WRITE_MASK = 8'hCF;
    localparam int LEVEL_BIT = 7;

    // Magnitude codes.
    localparam logic [3:0] MAG_OFF = 4'h0;
    localparam logic [3:0] MAG_LAST = 4'h9;

    // Routing codes.
    localparam logic [3:0] ROUTE_LAST_INPUT = 4'hB;
    localparam logic [3:0] ROUTE_COMMON = 4'hC;
    localparam logic [3:0] ROUTE_REFP = 4'h6;
    localparam logic [3:0] ROUTE_REFN = 4'h7;
    localparam logic [3:0] ROUTE_LAST_SMALL = 4'h7;

    // Decoded destination of one current source.
    typedef struct packed {
        logic [11:0] to_input;
        logic to_common;
        logic to_ref_positive;
        logic to_ref_negative;
    } source_route_t;

    // Sensor bias controls.
    typedef struct packed {
        logic generator_enable;
        logic level_twelfth;
        logic to_common;
        logic [5:0] to_input;
    } bias_ctrl_t;

endpackage

// ### verilog/excitation_bias_config_regs.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module excitation_bias_config_regs #(
    parameter int SIX_INPUT_VARIANT = 0
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device state.
    input wire logic power_down,
    // Analog controls.
    output logic rail_monitor_enable,
    output logic low_side_switch,
    output logic [3:0] current_magnitude,
    output excitation_bias_pkg::source_route_t first_source_route,
    output excitation_bias_pkg::source_route_t second_source_route,
    output excitation_bias_pkg::bias_ctrl_t bias_voltage
);

    logic [7:0] excitation_magnitude_reg;
    logic [7:0] current_routing_reg;
    logic [7:0] sensor_bias_control_reg;
    logic pd_meta_reg;
    logic pd_sync_reg;
    logic access;
    logic hit_mag;
    logic hit_route;
    logic hit_bias;
    logic mapped;
    excitation_bias_pkg::source_route_t first_next;
    excitation_bias_pkg::source_route_t second_next;
    excitation_bias_pkg::bias_ctrl_t bias_next;

    // The slave answers in the first access cycle, so no wait states are ever inserted.
    assign access = psel & penable;
    assign hit_mag = paddr == excitation_bias_pkg::MAG_ADDR;
    assign hit_route = paddr == excitation_bias_pkg::ROUTE_ADDR;
    assign hit_bias = paddr == excitation_bias_pkg::BIAS_ADDR;
    assign mapped = hit_mag | hit_route | hit_bias;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // Power-down arrives from another block's timing, so it is synchronised before use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_meta_reg <= 1'b0;
            pd_sync_reg <= 1'b0;
        end else begin
            pd_meta_reg <= power_down;
            pd_sync_reg <= pd_meta_reg;
        end
    end

    // Magnitude register; reserved bits 5:4 are masked so they can never hold a one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            excitation_magnitude_reg <= excitation_bias_pkg::MAG_RESET;
        end else if (access && pwrite && hit_mag) begin
            excitation_magnitude_reg <= pwdata[7:0] & excitation_bias_pkg::MAG_WRITE_MASK;
        end
    end

    // Routing register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_routing_reg <= excitation_bias_pkg::ROUTE_RESET;
        end else if (access && pwrite && hit_route) begin
            current_routing_reg <= pwdata[7:0];
        end
    end

    // Bias register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sensor_bias_control_reg <= excitation_bias_pkg::BIAS_RESET;
        end else if (access && pwrite && hit_bias) begin
            sensor_bias_control_reg <= pwdata[7:0];
        end
    end

    // Read mux; unmapped addresses read zero and raise pslverr.
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_mag) begin
            prdata[7:0] = excitation_magnitude_reg;
        end else if (hit_route) begin
            prdata[7:0] = current_routing_reg;
        end else if (hit_bias) begin
            prdata[7:0] = sensor_bias_control_reg;
        end
    end

    // Decode one routing field; a function keeps both sources on the same encoding.
    function automatic excitation_bias_pkg::source_route_t decode_route(input logic [3:0] code);
        excitation_bias_pkg::source_route_t r;
        r = '0;
        if (SIX_INPUT_VARIANT != 0) begin
            // The small part has only six inputs; codes 6 and 7 reach the second reference pins.
            if (code == excitation_bias_pkg::ROUTE_REFP) begin
                r.to_ref_positive = 1'b1;
            end else if (code == excitation_bias_pkg::ROUTE_REFN) begin
                r.to_ref_negative = 1'b1;
            end else if (code < excitation_bias_pkg::ROUTE_REFP) begin
                r.to_input[code] = 1'b1;
            end else if (code == excitation_bias_pkg::ROUTE_COMMON) begin
                r.to_common = 1'b1;
            end
        end else begin
            if (code <= excitation_bias_pkg::ROUTE_LAST_INPUT) begin
                r.to_input[code] = 1'b1;
            end else if (code == excitation_bias_pkg::ROUTE_COMMON) begin
                r.to_common = 1'b1;
            end
        end
        return r;
    endfunction

    // Output decode, registered so the analog controls never glitch.
    always_comb begin
        first_next = decode_route(current_routing_reg[3:0]);
        second_next = decode_route(current_routing_reg[7:4]);
        bias_next.level_twelfth = sensor_bias_control_reg[excitation_bias_pkg::LEVEL_BIT];
        bias_next.to_common = sensor_bias_control_reg[6];
        bias_next.to_input = sensor_bias_control_reg[5:0];
        bias_next.generator_enable = |sensor_bias_control_reg[6:0];
    end

    // Analog controls follow a written field at the next clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rail_monitor_enable <= 1'b0;
            low_side_switch <= 1'b0;
            current_magnitude <= excitation_bias_pkg::MAG_OFF;
            first_source_route <= '0;
            second_source_route <= '0;
            bias_voltage <= '0;
        end else begin
            rail_monitor_enable <= excitation_magnitude_reg[excitation_bias_pkg::RAIL_BIT];
            // Power-down overrides the stored switch bit so the load is never left powered.
            low_side_switch <= excitation_magnitude_reg[excitation_bias_pkg::SWITCH_BIT] & ~pd_sync_reg;
            // One shared magnitude drives both sources; undefined codes fall back to off.
            if (excitation_magnitude_reg[3:0] > excitation_bias_pkg::MAG_LAST) begin
                current_magnitude <= excitation_bias_pkg::MAG_OFF;
            end else begin
                current_magnitude <= excitation_magnitude_reg[3:0];
            end
            first_source_route <= first_next;
            second_source_route <= second_next;
            bias_voltage <= bias_next;
        end
    end

    // A write to the routing register shows on the routes two edges later.
    a_route_follows: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_route |-> ##2 first_source_route == decode_route($past(pwdata[3:0], 2)))
        else $error("First source route does not follow write.");

    a_switch_pd: assert property (@(posedge pclk) disable iff (!presetn)
        pd_sync_reg |=> !low_side_switch)
        else $error("Switch closed during power-down.");

    a_switch_bit: assert property (@(posedge pclk) disable iff (!presetn)
        !pd_sync_reg |=> low_side_switch == $past(excitation_magnitude_reg[6]))
        else $error("Switch does not follow stored bit.");

    a_rail_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 rail_monitor_enable == $past(excitation_magnitude_reg[7]))
        else $error("Rail monitor does not follow bit 7.");

    a_mag_range: assert property (@(posedge pclk) disable iff (!presetn)
        current_magnitude <= excitation_bias_pkg::MAG_LAST)
        else $error("Undefined magnitude driven.");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        excitation_magnitude_reg[5:4] == 2'b00)
        else $error("Reserved bits hold a one.");

    a_bias_enable: assert property (@(posedge pclk) disable iff (!presetn)
        bias_voltage.generator_enable == (bias_voltage.to_common | (|bias_voltage.to_input)))
        else $error("Bias generator enable wrong.");

    a_bias_level: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_bias |-> ##2 bias_voltage.level_twelfth == $past(pwdata[7], 2))
        else $error("Bias level does not follow write.");

    a_second_route: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 second_source_route == decode_route($past(current_routing_reg[7:4])))
        else $error("Second source route wrong.");

    // A bus write lands in the register at the edge that takes it, and the decoded output follows one edge later.
    sequence s_mag_write;
        access && pwrite && hit_mag;
    endsequence

    sequence s_route_write;
        access && pwrite && hit_route;
    endsequence

    sequence s_bias_write;
        access && pwrite && hit_bias;
    endsequence

    // The slave never stretches a transfer.
    a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        pready)
        else $error("Ready dropped.");

    // Unmapped words are refused with an error response.
    a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        access && !mapped |-> pslverr)
        else $error("Unmapped access not refused.");

    // Mapped words never report an error.
    a_slverr_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        access && mapped |-> !pslverr)
        else $error("Mapped access refused.");

    // A magnitude write stores every bit except the reserved pair.
    a_mag_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_mag_write |=> excitation_magnitude_reg == ($past(pwdata[7:0]) & excitation_bias_pkg::MAG_WRITE_MASK))
        else $error("Magnitude write not stored.");

    // A routing write stores the whole byte.
    a_route_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_route_write |=> current_routing_reg == $past(pwdata[7:0]))
        else $error("Routing write not stored.");

    // A bias write stores the whole byte.
    a_bias_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_bias_write |=> sensor_bias_control_reg == $past(pwdata[7:0]))
        else $error("Bias write not stored.");

    // Without a write the magnitude register holds its value.
    a_mag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_mag) |=> $stable(excitation_magnitude_reg))
        else $error("Magnitude register changed without a write.");

    // Without a write the routing register holds its value.
    a_route_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_route) |=> $stable(current_routing_reg))
        else $error("Routing register changed without a write.");

    // Without a write the bias register holds its value.
    a_bias_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_bias) |=> $stable(sensor_bias_control_reg))
        else $error("Bias register changed without a write.");

    // A source reaches at most one destination, so two pins are never shorted.
    a_first_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(first_source_route))
        else $error("First source routed to several pins.");

    // The same holds for the second source.
    a_second_onehot: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(second_source_route))
        else $error("Second source routed to several pins.");

    // The first route always follows the stored low field.
    a_first_route: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 first_source_route == decode_route($past(current_routing_reg[3:0])))
        else $error("First source route wrong.");

    // A magnitude write reaches the shared magnitude two edges later, undefined codes as off.
    a_mag_follows: assert property (@(posedge pclk) disable iff (!presetn)
        s_mag_write |-> ##2 current_magnitude == (($past(pwdata[3:0], 2) > excitation_bias_pkg::MAG_LAST) ? excitation_bias_pkg::MAG_OFF : $past(pwdata[3:0], 2)))
        else $error("Magnitude does not follow write.");

    // A magnitude write reaches the rail monitor enable two edges later.
    a_rail_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_mag_write |-> ##2 rail_monitor_enable == $past(pwdata[7], 2))
        else $error("Rail monitor does not follow write.");

    // Each input connection follows its own bit, whatever the others hold.
    a_bias_inputs: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 bias_voltage.to_input == $past(sensor_bias_control_reg[5:0]))
        else $error("Bias input connections wrong.");

    // The common connection follows bit 6.
    a_bias_common: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 bias_voltage.to_common == $past(sensor_bias_control_reg[6]))
        else $error("Bias common connection wrong.");

    // A bias write turns the generator on only when some connection bit is written high.
    a_bias_gen_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_bias_write |-> ##2 bias_voltage.generator_enable == (|$past(pwdata[6:0], 2)))
        else $error("Bias generator does not follow write.");

    // Only the low byte of a read word carries register bits.
    a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h00_0000)
        else $error("Upper read bits not zero.");

    // The reserved magnitude bits always read zero.
    a_read_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        hit_mag |-> prdata[5:4] == 2'b00)
        else $error("Reserved bits read as one.");

    // A power-down that follows a switch write still wins over the written bit.
    a_switch_pd_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_mag_write ##1 pd_sync_reg |=> !low_side_switch)
        else $error("Switch closed after write during power-down.");

    // The six-input build never drives the upper inputs.
    a_six_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (SIX_INPUT_VARIANT != 0) |-> (first_source_route.to_input[11:6] == 6'h00) && (second_source_route.to_input[11:6] == 6'h00))
        else $error("Six-input build routed to a missing input.");

    // The twelve-input build never reaches the second reference pins.
    a_twelve_no_ref: assert property (@(posedge pclk) disable iff (!presetn)
        (SIX_INPUT_VARIANT == 0) |-> !(first_source_route.to_ref_positive || first_source_route.to_ref_negative || second_source_route.to_ref_positive || second_source_route.to_ref_negative))
        else $error("Twelve-input build routed to a reference pin.");

    // A routing read returns the stored byte.
    a_route_read: assert property (@(posedge pclk) disable iff (!presetn)
        hit_route |-> prdata[7:0] == current_routing_reg)
        else $error("Routing read wrong.");

endmodule

`default_nettype wire

// ### testbench/excitation_bias_config_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

// One compare: counts it, and reports at once when the values differ.
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module excitation_bias_config_regs_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic power_down = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rail_monitor_enable;
    logic low_side_switch;
    logic [3:0] current_magnitude;
    excitation_bias_pkg::source_route_t first_source_route;
    excitation_bias_pkg::source_route_t second_source_route;
    excitation_bias_pkg::bias_ctrl_t bias_voltage;
    excitation_bias_pkg::source_route_t first_route6;
    excitation_bias_pkg::source_route_t second_route6;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_tests = 0;
    logic [7:0] bias_vals [6] = '{8'h80, 8'h40, 8'h01, 8'h3F, 8'hC5, 8'h00};

    excitation_bias_config_regs DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down(power_down), .rail_monitor_enable(rail_monitor_enable),
        .low_side_switch(low_side_switch), .current_magnitude(current_magnitude),
        .first_source_route(first_source_route), .second_source_route(second_source_route),
        .bias_voltage(bias_voltage)
    );

    // The six-input build shares the bus so its routing decode is checked alongside.
    excitation_bias_config_regs #(.SIX_INPUT_VARIANT(1)) six_input_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
        .power_down(power_down), .rail_monitor_enable(),
        .low_side_switch(), .current_magnitude(),
        .first_source_route(first_route6), .second_source_route(second_route6),
        .bias_voltage()
    );

    // A 25 ns period gives the 40 MHz bus clock.
    always #12.5 pclk = ~pclk;

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Outputs are registered one edge after the write lands, so look past that edge.
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask

    // Decoded destination expected for one routing code on the twelve-input build.
    function automatic logic [14:0] route_exp(input logic [3:0] c);
        if (c <= 4'hB) return {12'h001 << c, 3'b000};
        if (c == 4'hC) return 15'h0004;
        return 15'h0000;
    endfunction

    // Decoded destination expected on the six-input build.
    function automatic logic [14:0] route_exp6(input logic [3:0] c);
        if (c <= 4'h5) return {12'h001 << c, 3'b000};
        if (c == 4'h6) return 15'h0002;
        if (c == 4'h7) return 15'h0001;
        if (c == 4'hC) return 15'h0004;
        return 15'h0000;
    endfunction

    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #(25 * 5000);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset contents and outputs.
        apb(1'b0, excitation_bias_pkg::MAG_ADDR, 8'h00);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, excitation_bias_pkg::ROUTE_ADDR, 8'h00);
        `CHK(rd, 32'h0000_00FF)
        apb(1'b0, excitation_bias_pkg::BIAS_ADDR, 8'h00);
        `CHK(rd, 32'h0000_0000)
        `CHK({first_source_route, second_source_route}, 30'h0000_0000)
        `CHK({rail_monitor_enable, low_side_switch, bias_voltage}, 11'h000)
        // Reserved bits drop writes; an undefined magnitude code means off.
        apb(1'b1, excitation_bias_pkg::MAG_ADDR, 8'hFF);
        settle();
        `CHK({rail_monitor_enable, low_side_switch, current_magnitude}, 6'h30)
        apb(1'b0, excitation_bias_pkg::MAG_ADDR, 8'h00);
        `CHK(rd, 32'h0000_00CF)
        // Power-down passes two sync flops and the output register before forcing open.
        power_down <= 1'b1;
        repeat (5) @(posedge pclk);
        #1;
        `CHK(low_side_switch, 1'b0)
        power_down <= 1'b0;
        repeat (5) @(posedge pclk);
        #1;
        `CHK(low_side_switch, 1'b1)
        // Every magnitude code, with the switch and monitor bits cleared.
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, excitation_bias_pkg::MAG_ADDR, {4'h0, 4'(c)});
            settle();
            `CHK(current_magnitude, (c <= 9) ? 4'(c) : 4'h0)
        end
        `CHK({rail_monitor_enable, low_side_switch}, 2'b00)
        // Every routing code, different in the two fields at once.
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, excitation_bias_pkg::ROUTE_ADDR, {4'(c), 4'(15 - c)});
            settle();
            `CHK(second_source_route, route_exp(4'(c)))
            `CHK(first_source_route, route_exp(4'(15 - c)))
            `CHK(second_route6, route_exp6(4'(c)))
            `CHK(first_route6, route_exp6(4'(15 - c)))
        end
        // Bias level, connections and the generator enable.
        foreach (bias_vals[i]) begin
            apb(1'b1, excitation_bias_pkg::BIAS_ADDR, bias_vals[i]);
            settle();
            `CHK(bias_voltage, {|bias_vals[i][6:0], bias_vals[i]})
            apb(1'b0, excitation_bias_pkg::BIAS_ADDR, 8'h00);
            `CHK(rd, {24'h00_0000, bias_vals[i]})
        end
        // An unmapped word is refused and leaves the routing register alone.
        apb(1'b1, 12'h024, 8'h5A);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h024, 8'h00);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b0, excitation_bias_pkg::ROUTE_ADDR, 8'h00);
        `CHK({err, rd}, 33'h0_0000_00F0)
        test_done();
    end
endmodule

`undef CHK
`default_nettype wire
